// ===== mdt_dev.sv
// detector device end: serial slave, registers, pulse timing, target flag
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module mdt_dev
  import mdt_pkg::*;
#(
  parameter int TICK_CYC_P = MDT_TICK_CYC
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // serial bus
  mdt_if.dev              bus,
  // analog side
  input  wire logic [7:0] input_rail_i,
  output logic            detect_current_source_o,
  output logic            irq_out_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and filtered levels
  logic [2:0] scl_sy;
  logic [2:0] sda_sy;
  logic       scl_f;
  logic       sda_f;
  logic       scl_p;
  logic       sda_p;

  // three stages; a level counts only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
    end else begin
      scl_sy <= {scl_sy[1:0], bus.scl};
      sda_sy <= {sda_sy[1:0], bus.sda};
    end
  end

  // filtered levels and one-cycle history for edge detection
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      if (scl_sy[1] == scl_sy[2]) scl_f <= scl_sy[2];
      if (sda_sy[1] == sda_sy[2]) sda_f <= sda_sy[2];
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl_f & ~scl_p;
  assign scl_fall = ~scl_f & scl_p;
  assign start_c  = scl_f & scl_p & sda_p & ~sda_f;
  assign stop_c   = scl_f & scl_p & ~sda_p & sda_f;

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] timing;
  logic [7:0] target;
  logic [7:0] mask;
  logic       flag;

  // read view of the register map; unmapped offsets read zero
  function automatic logic [7:0] dev_read(input logic [7:0] ofs);
    case (ofs)
      MDT_OFS_STATUS: dev_read = 8'(flag) << MDT_FLAG_BIT;
      MDT_OFS_MASK:   dev_read = mask;
      MDT_OFS_TIMING: dev_read = timing;
      MDT_OFS_TARGET: dev_read = target;
      default:        dev_read = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // serial slave engine
  mdt_dstate_e st;
  logic [3:0]  cnt;
  logic [7:0]  shreg;
  logic [7:0]  tx;
  logic [7:0]  ptr;
  logic        first;
  logic        m_ack;
  logic        wr_stb;
  logic [7:0]  wr_ofs;
  logic [7:0]  wr_dat;
  logic        clr_stb;
  logic [7:0]  rd_byte;

  // byte the pointer selects; a named net, since a call result takes no bit-select
  assign rd_byte = dev_read(ptr);

  // the data pin only ever pulls low, so its output value stays zero
  assign bus.d_sda_o = 1'b0;

  // bit engine: shift on clock rise, drive or release on clock fall
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st           <= MDT_D_IDLE;
      cnt          <= 4'h0;
      shreg        <= 8'h00;
      tx           <= 8'h00;
      ptr          <= 8'h00;
      first        <= 1'b0;
      m_ack        <= 1'b0;
      bus.d_sda_oe <= 1'b0;
      wr_stb       <= 1'b0;
      wr_ofs       <= 8'h00;
      wr_dat       <= 8'h00;
      clr_stb      <= 1'b0;
    end else begin
      wr_stb  <= 1'b0;
      clr_stb <= 1'b0;
      if (start_c) begin // also a repeated start
        st           <= MDT_D_ADDR;
        cnt          <= 4'h0;
        first        <= 1'b1;
        bus.d_sda_oe <= 1'b0;
      end else if (stop_c) begin
        st           <= MDT_D_IDLE;
        bus.d_sda_oe <= 1'b0;
      end else begin
        case (st)
          MDT_D_IDLE: begin
            bus.d_sda_oe <= 1'b0;
          end
          MDT_D_ADDR, MDT_D_WR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_f};
              cnt   <= cnt + 4'h1;
            end else if (scl_fall && cnt == 4'h8) begin
              cnt <= 4'h0;
              if (st == MDT_D_ADDR) begin
                if (shreg[7:1] == MDT_SLV_ADDR) begin
                  bus.d_sda_oe <= 1'b1;
                  tx           <= {7'h00, shreg[0]};
                  shreg        <= 8'h00;
                  cnt          <= 4'h0;
                  st           <= MDT_D_AACK;
                end else begin
                  st <= MDT_D_IDLE; // other address: stay off the bus
                end
              end else begin
                bus.d_sda_oe <= 1'b1;
                st           <= MDT_D_WACK;
                first        <= 1'b0;
                if (first) begin
                  ptr <= shreg;
                end else begin
                  wr_stb <= 1'b1;
                  wr_ofs <= ptr;
                  wr_dat <= shreg;
                  ptr    <= ptr + 8'h01;
                end
              end
            end
          end
          MDT_D_AACK: begin
            if (scl_fall) begin
              if (tx[0]) begin
                // read: first data bit goes out on the same fall
                tx           <= rd_byte;
                bus.d_sda_oe <= ~rd_byte[7];
                clr_stb      <= (ptr == MDT_OFS_STATUS);
                st           <= MDT_D_RD;
              end else begin
                bus.d_sda_oe <= 1'b0;
                st           <= MDT_D_WR;
              end
            end
          end
          MDT_D_WACK: begin
            if (scl_fall) begin
              bus.d_sda_oe <= 1'b0;
              st           <= MDT_D_WR;
            end
          end
          MDT_D_RD: begin
            if (scl_rise) begin
              cnt <= cnt + 4'h1;
            end else if (scl_fall) begin
              if (cnt == 4'h8) begin
                bus.d_sda_oe <= 1'b0;
                cnt          <= 4'h0;
                ptr          <= ptr + 8'h01;
                st           <= MDT_D_RACK;
              end else begin
                tx           <= {tx[6:0], 1'b0};
                bus.d_sda_oe <= ~tx[6];
              end
            end
          end
          MDT_D_RACK: begin
            if (scl_rise) begin
              m_ack <= ~sda_f;
            end else if (scl_fall) begin
              if (m_ack) begin
                // master stays receiver: ack slot ends, next byte starts
                tx           <= rd_byte;
                bus.d_sda_oe <= ~rd_byte[7];
                clr_stb      <= (ptr == MDT_OFS_STATUS);
                st           <= MDT_D_RD;
              end else begin
                // no ack: keep released and wait for stop
                bus.d_sda_oe <= 1'b0;
                st           <= MDT_D_IDLE;
              end
            end
          end
          default: begin
            st           <= MDT_D_IDLE;
            bus.d_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      timing <= MDT_RST_TIMING;
      target <= MDT_RST_TARGET;
      mask   <= MDT_RST_MASK;
    end else if (wr_stb) begin
      case (wr_ofs)
        MDT_OFS_TIMING: timing <= wr_dat;
        MDT_OFS_TARGET: target <= wr_dat;
        MDT_OFS_MASK:   mask   <= wr_dat;
        default:        mask   <= mask;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 10 us tick divider; a parameter so simulation can shorten it
  logic [31:0] div;
  logic        tick;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div  <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (div == 32'(TICK_CYC_P - 1));
      div  <= (div == 32'(TICK_CYC_P - 1)) ? 32'h0 : div + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detection sequencer: a write to the timing register starts a cycle
  logic [3:0]  pw_code;
  logic [3:0]  pd_code;
  logic [31:0] pw_ticks;
  logic [31:0] pd_ticks;
  logic [31:0] on_cnt;
  logic [31:0] pd_cnt;
  logic        run;
  logic        restart;

  assign pw_code  = timing[7:4];
  assign pd_code  = timing[3:0];
  assign pw_ticks = 32'(mdt_pulse_us(pw_code) / MDT_TICK_US);
  assign pd_ticks = 32'(mdt_period_ms(pd_code) * 1000 / MDT_TICK_US);
  assign restart  = wr_stb && (wr_ofs == MDT_OFS_TIMING);

  // period is counted start to start, independent of pulse length
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      detect_current_source_o <= 1'b0;
      on_cnt                  <= 32'h0;
      pd_cnt                  <= 32'h0;
      run                     <= 1'b0;
    end else if (restart) begin
      detect_current_source_o <= 1'b1;
      on_cnt                  <= 32'h0;
      pd_cnt                  <= 32'h0;
      run                     <= 1'b1;
    end else if (run && tick) begin
      on_cnt <= on_cnt + 32'h1;
      pd_cnt <= pd_cnt + 32'h1;
      // continuous code wins even when period says single pulse
      if (pw_code == MDT_PW_CONT) begin
        detect_current_source_o <= 1'b1;
      end else if (on_cnt + 32'h1 >= pw_ticks) begin
        detect_current_source_o <= 1'b0;
      end
      if (pd_code != MDT_PD_SINGLE && pd_cnt + 32'h1 >= pd_ticks) begin
        detect_current_source_o <= 1'b1;
        on_cnt                  <= 32'h0;
        pd_cnt                  <= 32'h0;
      end else if (pd_code == MDT_PD_SINGLE && pw_code != MDT_PW_CONT &&
                   on_cnt + 32'h1 >= pw_ticks) begin
        run <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // target flag: set wins over the clear-on-read of the status register
  logic hit;
  // rail code and target share the 8 mV scale, so a plain compare suffices
  assign hit = detect_current_source_o && (input_rail_i > target);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flag <= 1'b0;
    end else if (hit) begin
      flag <= 1'b1;
    end else if (clr_stb) begin
      flag <= 1'b0;
    end
  end

  // interrupt pin low while flag stands and mask is clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_out_n_o <= 1'b1;
    end else begin
      irq_out_n_o <= ~(flag & ~mask[MDT_MASK_BIT]);
    end
  end

endmodule
`default_nettype wire

// ===== mdt_host.sv
// host end: serial bus master driven by a small command register port
`timescale 1ns/1ps
`default_nettype none
module mdt_host
  import mdt_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // command port
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // serial bus
  mdt_if.host             bus
);

  ////////////////////////////////////////////////////////////////////////////
  // data pin synchroniser
  logic [2:0] sda_sy;
  logic       sda_s;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sda_sy <= 3'h7;
      sda_s  <= 1'b1;
    end else begin
      sda_sy <= {sda_sy[1:0], bus.sda};
      if (sda_sy[1] == sda_sy[2]) sda_s <= sda_sy[2];
    end
  end

  // quarter bit enable; no clock stretching is expected from the device
  logic [15:0] qdiv;
  logic        qtick;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      qdiv  <= 16'h0;
      qtick <= 1'b0;
    end else begin
      qtick <= (qdiv == 16'(MDT_QTR_CYC - 1));
      qdiv  <= (qdiv == 16'(MDT_QTR_CYC - 1)) ? 16'h0 : qdiv + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command registers and master sequencer
  mdt_hstate_e st;
  logic [7:0]  reg_ofs;
  logic [7:0]  wdat;
  logic [7:0]  rdat;
  logic [7:0]  rxb;
  logic [7:0]  txb;
  logic [1:0]  q;
  logic [3:0]  bitn;
  logic [1:0]  step;
  logic        rd_op;
  logic        rd_ph;
  logic        busy;
  logic        nack;
  logic        rx_mode;

  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_o = 1'b0;
  // the single data byte of a read phase is received, then left unacked
  assign rx_mode = rd_ph && (step == 2'h1);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st           <= MDT_H_IDLE;
      reg_ofs      <= 8'h00;
      wdat         <= 8'h00;
      rdat         <= 8'h00;
      rxb          <= 8'h00;
      txb          <= 8'h00;
      q            <= 2'h0;
      bitn         <= 4'h0;
      step         <= 2'h0;
      rd_op        <= 1'b0;
      rd_ph        <= 1'b0;
      busy         <= 1'b0;
      nack         <= 1'b0;
      bus.m_scl_oe <= 1'b0;
      bus.m_sda_oe <= 1'b0;
    end else begin
      if (wr_i && addr_i == MDT_HOFS_REG) reg_ofs <= wdata_i;
      if (wr_i && addr_i == MDT_HOFS_DATA) wdat <= wdata_i;
      if (qtick && st != MDT_H_IDLE) q <= q + 2'h1;
      case (st)
        MDT_H_IDLE: begin
          if (wr_i && addr_i == MDT_HOFS_CTRL &&
              (wdata_i[MDT_CTRL_WR] || wdata_i[MDT_CTRL_RD])) begin
            st    <= MDT_H_START;
            q     <= 2'h0;
            rd_op <= wdata_i[MDT_CTRL_RD];
            rd_ph <= 1'b0;
            busy  <= 1'b1;
            nack  <= 1'b0;
          end
        end
        MDT_H_START: begin
          if (qtick) begin
            case (q)
              2'h0: bus.m_sda_oe <= 1'b0;
              2'h1: bus.m_sda_oe <= 1'b1;
              2'h2: bus.m_scl_oe <= 1'b1;
              default: begin
                st   <= MDT_H_BYTE;
                bitn <= 4'h0;
                step <= 2'h0;
                txb  <= {MDT_SLV_ADDR, rd_ph};
              end
            endcase
          end
        end
        MDT_H_BYTE: begin
          if (qtick) begin
            case (q)
              2'h0: bus.m_sda_oe <= (bitn < 4'h8) && !rx_mode && !txb[7];
              2'h1: bus.m_scl_oe <= 1'b0;
              2'h2: begin
                if (bitn < 4'h8) rxb <= {rxb[6:0], sda_s};
                else if (!rx_mode && sda_s) nack <= 1'b1;
              end
              default: begin
                bus.m_scl_oe <= 1'b1;
                txb          <= {txb[6:0], 1'b0};
                bitn         <= bitn + 4'h1;
                if (bitn == 4'h8) begin
                  bitn <= 4'h0;
                  step <= step + 2'h1;
                  txb  <= (step == 2'h0) ? reg_ofs : wdat;
                  if (rx_mode) rdat <= rxb;
                  if (nack || rx_mode || (rd_op && step == 2'h1) || step == 2'h2)
                    st <= MDT_H_STOP;
                end
              end
            endcase
          end
        end
        MDT_H_STOP: begin
          if (qtick) begin
            case (q)
              2'h0: bus.m_sda_oe <= 1'b1;
              2'h1: bus.m_scl_oe <= 1'b0;
              2'h2: bus.m_sda_oe <= 1'b0;
              default: begin
                if (rd_op && !rd_ph && !nack) begin
                  rd_ph <= 1'b1;
                  st    <= MDT_H_START;
                end else begin
                  busy <= 1'b0;
                  st   <= MDT_H_IDLE;
                end
              end
            endcase
          end
        end
        default: st <= MDT_H_IDLE;
      endcase
    end
  end

  // read data appears in the cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        MDT_HOFS_REG:  rdata_o <= reg_ofs;
        MDT_HOFS_DATA: rdata_o <= rdat;
        MDT_HOFS_CTRL: rdata_o <= {6'h00, nack, busy};
        default:       rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ===== mdt_if.sv
// two-wire bus joining the detector device and its host master
`timescale 1ns/1ps
`default_nettype none
interface mdt_if;
  logic scl;
  logic sda;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  // open-drain wired-and; released lines float high
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));
  modport dev  (input scl, sda, output d_sda_o, d_sda_oe);
  modport host (input scl, sda, output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe);
endinterface
`default_nettype wire

// ===== mdt_monitor.sv
// bus checker for the detector and host ends
`timescale 1ns/1ps
`default_nettype none
module mdt_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // resolved lines and pull-low enables
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic m_scl_oe_i,
  input wire logic m_sda_oe_i,
  input wire logic d_sda_oe_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [13:0] hold_cnt;
  // length of one device drive; a stuck enable would hang the bus for good
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !d_sda_oe_i) hold_cnt <= 14'h0000;
    else if (hold_cnt != 14'h3FFF) hold_cnt <= hold_cnt + 14'h0001;
  end
  property p_rst_rel; @(posedge clk_i) disable iff (1'b0)
    !rst_n_i |=> !m_scl_oe_i && !m_sda_oe_i && !d_sda_oe_i; endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("bus held in reset");
  property p_dev_hold; scl_i && $past(scl_i) |-> $stable(d_sda_oe_i); endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("device moved sda, scl high");
  property p_start; $fell(sda_i) && scl_i && $past(scl_i) |->
    m_sda_oe_i && !d_sda_oe_i; endproperty
  a_start: assert property (p_start) else $error("start not made by host");
  property p_stop; $rose(sda_i) && scl_i && $past(scl_i) |=> !d_sda_oe_i [*8]; endproperty
  a_stop: assert property (p_stop) else $error("device drove after stop");
  property p_ack_set; $rose(d_sda_oe_i) |-> !scl_i && !$past(scl_i, 3); endproperty
  a_ack_set: assert property (p_ack_set) else $error("drive began off scl low");
  property p_ack_rel; $fell(d_sda_oe_i) |-> !scl_i && !$past(scl_i, 3); endproperty
  a_ack_rel: assert property (p_ack_rel) else $error("release off scl low");
  property p_hold_len; hold_cnt <= 14'h2454; endproperty
  a_hold_len: assert property (p_hold_len) else $error("device drive too long");
  property p_clk_pulse; $rose(scl_i) |-> scl_i [*8]; endproperty
  a_clk_pulse: assert property (p_clk_pulse) else $error("scl pulse too short");
endmodule
`default_nettype wire

// ===== mdt_pkg.sv
// constants, tables and types shared by the moisture detect timing ends
// Operation
// - pulse width code in timing upper nibble
// - period code in lower nibble, zero single
// - continuous-on beats single pulse at F0
// - 8-bit read/write target register, reset zero
// - target code is linear, 8 mV steps
// - rail above target sets flag, raises interrupt
// - idle bus leaves clock and data high
// - start is data falling while clock high
// - stop is data rising while clock high
// - change data on low, sample on high
// - bytes of eight bits, count unlimited
// - register address increments after every byte
// - receiver pulls data low after eighth bit
// - missing acknowledge means failed transfer
// - release acknowledge at ninth falling edge
// - last read byte unacknowledged, await stop
// - answer only to address 1101100 plus R/W
// - mask bit set blocks target interrupt
`default_nettype none
package mdt_pkg;
  // bus address and register map
  localparam logic [6:0] MDT_SLV_ADDR   = 7'h6C;
  localparam logic [7:0] MDT_OFS_STATUS = 8'h02;
  localparam logic [7:0] MDT_OFS_MASK   = 8'h04;
  localparam logic [7:0] MDT_OFS_TIMING = 8'h07;
  localparam logic [7:0] MDT_OFS_TARGET = 8'h09;
  localparam int         MDT_FLAG_BIT   = 6;
  localparam int         MDT_MASK_BIT   = 6;
  localparam logic [7:0] MDT_RST_TIMING = 8'h00;
  localparam logic [7:0] MDT_RST_TARGET = 8'h00;
  localparam logic [7:0] MDT_RST_MASK   = 8'h00;
  localparam logic [3:0] MDT_PW_CONT    = 4'hF;
  localparam logic [3:0] MDT_PD_SINGLE  = 4'h0;
  // target step in mV; code n means n * 8 mV, 255 means 2.04 V
  localparam int         MDT_TARGET_MV_STEP = 8;
  // timing base: detection counts in 10 us ticks
  localparam int         MDT_CLK_MHZ    = 100;
  localparam int         MDT_TICK_US    = 10;
  localparam int         MDT_TICK_CYC   = MDT_TICK_US * MDT_CLK_MHZ;
  localparam int         MDT_SCL_KHZ    = 100;
  localparam int         MDT_QTR_CYC    = MDT_CLK_MHZ * 1000 / (MDT_SCL_KHZ * 4);
  // host command port map
  localparam logic [1:0] MDT_HOFS_REG   = 2'h0;
  localparam logic [1:0] MDT_HOFS_DATA  = 2'h1;
  localparam logic [1:0] MDT_HOFS_CTRL  = 2'h2;
  localparam int         MDT_CTRL_WR    = 0;
  localparam int         MDT_CTRL_RD    = 1;

  // device serial states
  typedef enum logic [6:0] {
    MDT_D_IDLE = 7'b0000001, MDT_D_ADDR = 7'b0000010, MDT_D_AACK = 7'b0000100,
    MDT_D_WR   = 7'b0001000, MDT_D_WACK = 7'b0010000, MDT_D_RD   = 7'b0100000,
    MDT_D_RACK = 7'b1000000
  } mdt_dstate_e;

  // host serial states
  typedef enum logic [3:0] {
    MDT_H_IDLE = 4'b0001, MDT_H_START = 4'b0010, MDT_H_BYTE = 4'b0100,
    MDT_H_STOP = 4'b1000
  } mdt_hstate_e;

  // source pulse width in us per code; code 15 is continuous
  function automatic int unsigned mdt_pulse_us(input logic [3:0] code);
    case (code)
      4'h0: mdt_pulse_us = 200;      4'h1: mdt_pulse_us = 400;
      4'h2: mdt_pulse_us = 1000;     4'h3: mdt_pulse_us = 2000;
      4'h4: mdt_pulse_us = 4000;     4'h5: mdt_pulse_us = 10000;
      4'h6: mdt_pulse_us = 20000;    4'h7: mdt_pulse_us = 40000;
      4'h8: mdt_pulse_us = 100000;   4'h9: mdt_pulse_us = 200000;
      4'hA: mdt_pulse_us = 400000;   4'hB: mdt_pulse_us = 1000000;
      4'hC: mdt_pulse_us = 2000000;  4'hD: mdt_pulse_us = 4000000;
      4'hE: mdt_pulse_us = 10000000;
      default: mdt_pulse_us = 0;
    endcase
  endfunction

  // detection period in ms per code; code 0 is a single pulse
  function automatic int unsigned mdt_period_ms(input logic [3:0] code);
    case (code)
      4'h1: mdt_period_ms = 10;      4'h2: mdt_period_ms = 20;
      4'h3: mdt_period_ms = 50;      4'h4: mdt_period_ms = 100;
      4'h5: mdt_period_ms = 200;     4'h6: mdt_period_ms = 500;
      4'h7: mdt_period_ms = 1000;    4'h8: mdt_period_ms = 2000;
      4'h9: mdt_period_ms = 3000;    4'hA: mdt_period_ms = 6000;
      4'hB: mdt_period_ms = 12000;   4'hC: mdt_period_ms = 30000;
      4'hD: mdt_period_ms = 60000;   4'hE: mdt_period_ms = 120000;
      4'hF: mdt_period_ms = 300000;
      default: mdt_period_ms = 0;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== tb.sv
// self-checking bench: host and detector ends joined on one bus
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mdt_pkg::*;
  localparam int TICK_P = 2;
  logic       clk_i;
  logic       rst_n_i;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [7:0] rail;
  logic       src;
  logic       irq_n;
  logic [7:0] seen;
  int         miscompares;
  int         checks;
  int         src_cnt = 0;
  int         seed;
  int         tgt;
  int         pw;
  int         mdl [int];
  mdt_if bus ();
  mdt_host u_mdt_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .bus(bus));
  mdt_dev #(.TICK_CYC_P(TICK_P)) u_mdt_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus),
    .input_rail_i(rail), .detect_current_source_o(src), .irq_out_n_o(irq_n));
  mdt_monitor u_mdt_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(bus.scl),
    .sda_i(bus.sda), .m_scl_oe_i(bus.m_scl_oe), .m_sda_oe_i(bus.m_sda_oe),
    .d_sda_oe_i(bus.d_sda_oe));
  // free-running clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // on-time of the source, counted by the bench itself
  always @(posedge clk_i) if (src === 1'b1) src_cnt <= src_cnt + 1;
  function automatic int xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed & 32'h7FFFFFFF;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one-cycle command strobe; read data lands in seen
  task automatic cmd(input logic [1:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 seen = rdata;
  endtask
  // one register byte across the bus, busy polled under a bound
  task automatic xfer(input logic [7:0] ofs, input logic [7:0] d, input logic [7:0] go);
    int n;
    cmd(MDT_HOFS_REG, ofs, 1'b1);
    cmd(MDT_HOFS_DATA, d, 1'b1);
    cmd(MDT_HOFS_CTRL, go, 1'b1);
    n = 0;
    seen = 8'h01;
    while (seen[0] !== 1'b0 && n < 30000) begin
      cmd(MDT_HOFS_CTRL, 8'h00, 1'b0);
      n++;
    end
    if (seen[0] !== 1'b0) begin
      miscompares++;
      finish_test();
    end
  endtask
  // main sequence: target, single pulse, read back
  initial begin
    rst_n_i = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    rail = 8'h00;
    miscompares = 0;
    checks = 0;
    seed = 5052;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    tgt = xorshift() % 255;
    rail <= 8'(tgt + 1);
    check({7'h00, irq_n}, 8'h01, "irq idle");
    xfer(MDT_OFS_TARGET, 8'(tgt), 8'h01);
    mdl[MDT_OFS_TARGET] = tgt;
    check({7'h00, irq_n}, 8'h01, "irq with source off");
    $display("test target write done");
    xfer(MDT_OFS_TIMING, 8'h00, 8'h01);
    pw = 200 / MDT_TICK_US * TICK_P;
    check({7'h00, src_cnt >= pw - 1 && src_cnt <= pw + 1}, 8'h01, "pulse width");
    check({7'h00, src}, 8'h00, "single pulse over");
    check({7'h00, irq_n}, 8'h00, "irq on target");
    $display("test pulse done");
    xfer(MDT_OFS_TARGET, 8'h00, 8'h02);
    cmd(MDT_HOFS_DATA, 8'h00, 1'b0);
    check(seen, 8'(mdl[MDT_OFS_TARGET]), "target readback");
    cmd(MDT_HOFS_CTRL, 8'h00, 1'b0);
    check(seen, 8'h00, "address answered");
    $display("test read done");
    finish_test();
  end
endmodule
`default_nettype wire
